// ===== verilog/rsc_cfg.svh
/*
 * Constants for the reset-source capture block: register address, page,
 * bit positions, reset values and timing counts.
 * Assumes inclusion by bare name from design files under verilog/.
 */
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_SFR_ADDR 8'hEF
`define RSC_SFR_PAGE 8'h00
`define RSC_BIT_PIN 0
`define RSC_BIT_POR 1
`define RSC_BIT_CLK 2
`define RSC_BIT_WDT 3
`define RSC_BIT_SW 4
`define RSC_BIT_CMP 5
`define RSC_BIT_FLASH 6
`define RSC_EN_RESET 1'b0
`define RSC_CAUSE_RESET 7'h02
`define RSC_HOLD_NS 40
`define RSC_CLK_MHZ 200
`define RSC_HOLD_CYC (((`RSC_HOLD_NS * `RSC_CLK_MHZ) + 999) / 1000)

`endif

// ===== verilog/rsc_pkg.sv
/*
 * Types shared by the reset-source capture block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rsc_pkg;
   typedef enum logic [2:0] {
      RSC_SRC_NONE,
      RSC_SRC_POR,
      RSC_SRC_PIN,
      RSC_SRC_CLK,
      RSC_SRC_CMP,
      RSC_SRC_WDT,
      RSC_SRC_SW,
      RSC_SRC_FLASH
   } rsc_src_t;

   typedef enum logic [1:0] {
      RSC_RUN,
      RSC_HOLD,
      RSC_RELEASE
   } rsc_state_t;
endpackage : rsc_pkg

// ===== verilog/rsc_sync.sv
/*
 * Two-flip-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs are quasi-static levels; no multi-bit coherence is given.
 */
`timescale 1ns/1ps
`default_nettype none

module rsc_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // First stage is read only by the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : rsc_sync

`default_nettype wire

// ===== verilog/rsc_reset_source.sv
/*
 * Reset-cause and reset-enable register with the system reset request
 * generator. Records which source caused the last system reset.
 * Assumes: rstn is the power-on reset only; system resets requested by this
 * block are tracked by its own request sequencer state.
 * Source requests other than flash_fault and the software force are asynchronous levels and are synchronised here.
 */
//
// Operation
// R01: Register sits at address 0xEF, page 0x00; eight bits, bit 7 reads zero.
// R02: Bit 6 reads 1 only after a flash-error reset.
// R03: Writing 1 to bit 5 enables low comparator output as reset source.
// R04: Bit 5 reads 1 only after a comparator-caused reset.
// R05: Writing 1 to bit 4 forces a full system reset at once.
// R06: Bit 4 reads 1 after a software-forced reset.
// R07: Bit 3 reads 1 after a watchdog reset; writes ignored.
// R08: Writing 1 to bit 2 enables the clock-loss detector reset.
// R09: Enabled clock-loss detector resets device; bit 2 then reads 1.
// R10: Writing 1 to bit 1 enables the supply monitor reset.
// R11: Software enables supply-monitor reset only after monitor is stable.
// R12: Bit 1 reads 1 after power-on or monitor reset; others undefined.
// R13: Bit 0 reads 1 after an external pin reset; writes ignored.
// R14: Software must not read-modify-write this register.
// R15: Writing 0 to the clock-loss enable disables the detector.
// R16: Enabled comparator resets device while its output is low. The code clears the enable at reset, so the request ends after the hold count.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_reset_source #(
   parameter int HOLD_CYC = `RSC_HOLD_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic ext_reset_pin_n,
   input wire logic comparator_out,
   input wire logic clock_loss_detector,
   input wire logic supply_low,
   input wire logic watchdog_overflow,
   input wire logic flash_fault,
   output logic sys_reset_req,
   output logic clock_loss_enable_out,
   output logic supply_monitor_enable_out
);
   ////////////////////////////////////////////////////////////////////////
   // Synchronised source levels
   logic [4:0] src_raw;
   logic [4:0] src_sync;
   logic pin_low;
   logic cmp_low;
   logic clk_lost;
   logic vdd_low;
   logic wdt_hit;

   assign src_raw = {watchdog_overflow, supply_low, clock_loss_detector, ~comparator_out, ~ext_reset_pin_n};

   // Every source but flash_fault and the software force passes two stages; the sync clears to zero, which is the
   // idle level of each line once the low-true pin and comparator are inverted
   rsc_sync #(
      .WIDTH(5)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(src_raw),
      .sync_out(src_sync)
   );

   assign pin_low = src_sync[0];
   assign cmp_low = src_sync[1];
   assign clk_lost = src_sync[2];
   assign vdd_low = src_sync[3];
   assign wdt_hit = src_sync[4];

   ////////////////////////////////////////////////////////////////////////
   // Register access decode
   logic sel;
   logic wr_hit;

   assign sel = (sfr_addr == `RSC_SFR_ADDR) && (sfr_page == `RSC_SFR_PAGE); // [R01]
   assign wr_hit = sel && sfr_wr;

   ////////////////////////////////////////////////////////////////////////
   // Enable bits; written bits take effect the cycle after the write
   logic cmp_en_q;
   logic clk_en_q;
   logic vdd_en_q;
   logic sw_force;
   logic in_reset;

   assign sw_force = wr_hit && sfr_wdata[`RSC_BIT_SW]; // [R05]

   // Enables drop at every system reset so sources start disabled
   // A write landing on the edge a reset starts is lost; software writes again
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmp_en_q <= `RSC_EN_RESET;
         clk_en_q <= `RSC_EN_RESET;
         vdd_en_q <= `RSC_EN_RESET;
      end else if (in_reset) begin
         cmp_en_q <= `RSC_EN_RESET;
         clk_en_q <= `RSC_EN_RESET;
         vdd_en_q <= `RSC_EN_RESET;
      end else if (wr_hit) begin
         cmp_en_q <= sfr_wdata[`RSC_BIT_CMP]; // [R03]
         clk_en_q <= sfr_wdata[`RSC_BIT_CLK]; // [R08] [R15]
         vdd_en_q <= sfr_wdata[`RSC_BIT_POR]; // [R10]
      end
   end

   assign clock_loss_enable_out = clk_en_q;
   assign supply_monitor_enable_out = vdd_en_q;

   ////////////////////////////////////////////////////////////////////////
   // Source arbitration; power and pin take priority, then the rest
   rsc_pkg::rsc_src_t src_now;

   always_comb begin
      src_now = rsc_pkg::RSC_SRC_NONE;
      if (vdd_en_q && vdd_low) begin
         src_now = rsc_pkg::RSC_SRC_POR;
      end else if (pin_low) begin
         src_now = rsc_pkg::RSC_SRC_PIN;
      end else if (clk_en_q && clk_lost) begin
         src_now = rsc_pkg::RSC_SRC_CLK; // [R09]
      end else if (cmp_en_q && cmp_low) begin
         src_now = rsc_pkg::RSC_SRC_CMP; // [R16]
      end else if (wdt_hit) begin
         src_now = rsc_pkg::RSC_SRC_WDT;
      end else if (flash_fault) begin
         src_now = rsc_pkg::RSC_SRC_FLASH;
      end else if (sw_force) begin
         src_now = rsc_pkg::RSC_SRC_SW;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset request sequencer: hold the request at least HOLD_CYC cycles
   // and until the reset pin has gone away; the comparator, clock-loss and supply sources lose their enables at reset
   rsc_pkg::rsc_state_t state_q;
   logic [15:0] hold_q;
   logic level_active;

   assign level_active = pin_low || (vdd_low && vdd_en_q) || (clk_lost && clk_en_q) || (cmp_low && cmp_en_q);
   assign in_reset = (state_q != rsc_pkg::RSC_RUN);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= rsc_pkg::RSC_HOLD;
         hold_q <= 16'h0000;
      end else begin
         case (state_q)
            rsc_pkg::RSC_RUN: begin
               if (src_now != rsc_pkg::RSC_SRC_NONE) begin
                  state_q <= rsc_pkg::RSC_HOLD;
                  hold_q <= 16'h0000;
               end
            end
            rsc_pkg::RSC_HOLD: begin
               // Count first, then wait for the pin, the one source still counted in level_active once the enables clear, to let go; a pulse
               // source shorter than the count still gets the full hold time
               if (hold_q >= 16'(HOLD_CYC - 1) && !level_active) begin
                  state_q <= rsc_pkg::RSC_RELEASE;
               end else if (hold_q < 16'(HOLD_CYC - 1)) begin
                  hold_q <= hold_q + 16'h0001;
               end
            end
            rsc_pkg::RSC_RELEASE: begin
               state_q <= rsc_pkg::RSC_RUN;
            end
            default: begin
               state_q <= rsc_pkg::RSC_HOLD;
            end
         endcase
      end
   end

   // Enables were cleared above, so only the pin can hold the request
   assign sys_reset_req = in_reset;

   ////////////////////////////////////////////////////////////////////////
   // Cause flags; captured when a reset begins, held until the next one
   logic [6:0] cause_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cause_q <= `RSC_CAUSE_RESET; // Power-on reset reads as bit 1 [R12]
      end else if (state_q == rsc_pkg::RSC_RUN && src_now != rsc_pkg::RSC_SRC_NONE) begin
         // Only the winning source is recorded, so exactly one flag reads 1
         cause_q <= 7'h00;
         case (src_now)
            rsc_pkg::RSC_SRC_POR: cause_q[`RSC_BIT_POR] <= 1'b1; // [R12]
            rsc_pkg::RSC_SRC_PIN: cause_q[`RSC_BIT_PIN] <= 1'b1; // [R13]
            rsc_pkg::RSC_SRC_CLK: cause_q[`RSC_BIT_CLK] <= 1'b1; // [R09]
            rsc_pkg::RSC_SRC_CMP: cause_q[`RSC_BIT_CMP] <= 1'b1; // [R04]
            rsc_pkg::RSC_SRC_WDT: cause_q[`RSC_BIT_WDT] <= 1'b1; // [R07]
            rsc_pkg::RSC_SRC_SW: cause_q[`RSC_BIT_SW] <= 1'b1; // [R06]
            rsc_pkg::RSC_SRC_FLASH: cause_q[`RSC_BIT_FLASH] <= 1'b1; // [R02]
            default: cause_q <= 7'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data: flags in 6:0, bit 7 zero; writes never touch flags
   // Registered so the bus sees the flags one cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata <= 8'h00;
      end else if (sel && sfr_rd) begin
         sfr_rdata <= {1'b0, cause_q}; // [R01]
      end else begin
         sfr_rdata <= 8'h00;
      end
   end
endmodule : rsc_reset_source

`default_nettype wire

// ===== sim/rsc_src_model.sv
/* Model of the on-chip reset sources.
   Assumes the bench gives a one-hot select. */
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
   input wire logic [5:0] act,
   output logic [5:0] src
);
   // Each level stands while selected; pin and comparator are low-true
   assign src = act ^ 6'h03;
endmodule : rsc_src_model
`default_nettype wire

// ===== sim/rsc_props.sv
/* Checker for the reset-source block.
   Assumes binding to the block's own ports. */
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
module rsc_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic ext_reset_pin_n,
   input wire logic clock_loss_detector,
   input wire logic watchdog_overflow,
   input wire logic sys_reset_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////
   // A write the block takes; writes during a request are refused
   sequence s_take;
      sfr_wr && sfr_addr == `RSC_SFR_ADDR && sfr_page == `RSC_SFR_PAGE && !sys_reset_req;
   endsequence
   // Sources pass two sync stages and one request stage, so three samples would do; four are taken
   a_sw_force: assert property (s_take ##0 sfr_wdata[4] |=> sys_reset_req)
      else $error("no soft reset");
   a_req_holds: assert property ($rose(sys_reset_req) |=> sys_reset_req [*2])
      else $error("reset too short");
   a_pin_reset: assert property (!ext_reset_pin_n [*4] |=> sys_reset_req)
      else $error("no pin reset");
   a_wdt_reset: assert property (watchdog_overflow [*4] |=> sys_reset_req)
      else $error("no watchdog reset");
   // The detector rises two samples after the enable write in the bench
   a_loss_reset: assert property (s_take ##0 sfr_wdata[2] ##2 clock_loss_detector [*4] |=> sys_reset_req)
      else $error("no clock loss reset");
   a_read_src: assert property (sfr_rdata != 8'h00 |-> $past(sfr_rd) && $past(sfr_addr) == `RSC_SFR_ADDR)
      else $error("data without read");
   a_bit7_zero: assert property (!sfr_rdata[7])
      else $error("bit 7 set");
   a_page_only: assert property (sfr_rd && sfr_page != 8'h00 |=> sfr_rdata == 8'h00)
      else $error("wrong page answered");
endmodule : rsc_props
bind rsc_reset_source rsc_props u_props (.clk, .rstn, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
   .sfr_rdata, .ext_reset_pin_n, .clock_loss_detector, .watchdog_overflow, .sys_reset_req);
`default_nettype wire

// ===== sim/tb_top.sv
/* Bench for the reset-source block.
   Assumes design, source model and checker compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"
module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_page = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [5:0] act = 6'h00;
   logic [5:0] src;
   logic sys_reset_req;
   wire logic [1:0] en;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   rsc_src_model u_src (.act, .src);
   rsc_reset_source #(.HOLD_CYC(2)) DUT (.clk, .rstn, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .ext_reset_pin_n(src[0]), .comparator_out(src[1]), .clock_loss_detector(src[2]),
      .supply_low(src[3]), .watchdog_overflow(src[4]), .flash_fault(src[5]), .sys_reset_req,
      .clock_loss_enable_out(en[1]), .supply_monitor_enable_out(en[0]));
   ////////////////////
   task automatic complete_run();
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // Whole bytes only, never read back and modified
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_page <= p;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_page <= p;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      d = sfr_rdata;
   endtask : rd_reg
   // Bounded wait for the request level
   task automatic wait_req(input logic lvl);
      int n;
      n = 0;
      while (sys_reset_req !== lvl && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({7'h00, sys_reset_req}, {7'h00, lvl});
   endtask : wait_req
   // Enable, fire one source, let the reset pass, read the cause
   task automatic src_case(input logic [5:0] s, input logic [7:0] e, input logic [7:0] exp);
      logic [7:0] d;
      if (e != 8'h00)
         wr_reg(`RSC_SFR_ADDR, 8'h00, e);
      @(posedge clk);
      act <= s;
      wait_req(1'b1);
      @(posedge clk);
      act <= 6'h00;
      wait_req(1'b0);
      rd_reg(`RSC_SFR_ADDR, 8'h00, d);
      chk(d, exp);
   endtask : src_case
   task automatic t_por();
      logic [7:0] d;
      rd_reg(`RSC_SFR_ADDR, 8'h00, d);
      chk(d, 8'h02);
      rd_reg(8'hEE, 8'h00, d);
      chk(d, 8'h00);
      rd_reg(`RSC_SFR_ADDR, 8'h01, d);
      chk(d, 8'h00);
      wr_reg(`RSC_SFR_ADDR, 8'h01, 8'h10);
      @(posedge clk);
      #1;
      chk({7'h00, sys_reset_req}, 8'h00);
   endtask : t_por
   task automatic t_sources();
      logic [7:0] d;
      src_case(6'h00, 8'h10, 8'h10);
      src_case(6'h10, 8'h00, 8'h08);
      src_case(6'h20, 8'h00, 8'h40);
      src_case(6'h01, 8'h00, 8'h01);
      src_case(6'h02, 8'h20, 8'h20);
      src_case(6'h04, 8'h04, 8'h04);
      src_case(6'h08, 8'h02, 8'h02); // Monitor enabled while supply is good
      wr_reg(`RSC_SFR_ADDR, 8'h00, 8'h49);
      rd_reg(`RSC_SFR_ADDR, 8'h00, d);
      chk(d, 8'h02);
   endtask : t_sources
   task automatic t_enables();
      wr_reg(`RSC_SFR_ADDR, 8'h00, 8'h04);
      chk({6'h00, en}, 8'h02);
      wr_reg(`RSC_SFR_ADDR, 8'h00, 8'h02);
      chk({6'h00, en}, 8'h01);
      @(posedge clk);
      act <= 6'h02;
      repeat (8) @(posedge clk);
      #1;
      chk({7'h00, sys_reset_req}, 8'h00);
      @(posedge clk);
      act <= 6'h00;
   endtask : t_enables
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      wait_req(1'b0);
      t_por();
      t_sources();
      t_enables();
      complete_run();
   end
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end
endmodule : tb_top
`default_nettype wire
